// ### design/nix_seq.sv
// Noninterlocked data transfer sequencer, channel side of the drive link
`timescale 1ns/1ps
`include "nix_defs.svh"
module nix_seq #(
    parameter int PEND_W = `NIX_PEND_W,
    parameter int FIFO_DEPTH = `NIX_FIFO_DEPTH
) (
    input wire logic clk,                          // 10 MHz clock
    input wire logic rst,                          // Synchronous reset, active high
    input wire logic start,                        // Request a transfer
    input wire logic dir_from_disk,                // 1: from disk, 0: to disk
    input wire logic bus_ctl_done,                 // Bus control sequence succeeded
    input wire logic abort,                        // Error: terminate transfer
    input wire logic status_done,                  // Ending status sequence finished
    input wire logic host_tx_valid,                // Host offers a parcel for disk
    output logic host_tx_ready,                    // Parcel taken
    input wire nix_pkg::nix_parcel_t host_tx_data, // Parcel for disk
    output logic host_rx_valid,                    // Parcel from disk available
    input wire logic host_rx_ready,                // Host takes parcel
    output nix_pkg::nix_parcel_t host_rx_data,     // Parcel from disk
    output logic busy,                             // Transfer or status pending
    output logic status_req,                       // Ending status must run now
    output logic xfer_good,                        // Last transfer ended without error
    output logic overrun,                          // A parcel from disk was lost
    input wire nix_pkg::nix_drv_in_t drv_in,       // Pins from the drive
    output nix_pkg::nix_drv_out_t drv_out          // Pins to the drive
);
    typedef struct packed
    {
        nix_pkg::nix_state_t state;
        nix_pkg::nix_phase_t phase;
        logic [2:0] sin_p;
        logic [2:0] slv_p;
        nix_pkg::nix_parcel_t [2:0] bus_p;
        logic sin_f;
        logic slv_f;
        logic from_disk;
        logic abort_req;
        logic term;
        logic good;
        logic overrun;
        logic [PEND_W-1:0] pending;
        logic [`NIX_POST_W-1:0] post;
        nix_pkg::nix_drv_out_t out;
    } nix_seq_st_t;

    nix_seq_st_t r;
    nix_seq_st_t next_r;

    logic f_in_valid;
    logic f_in_ready;
    nix_pkg::nix_parcel_t f_in_data;
    logic f_out_valid;
    logic f_out_ready;
    nix_pkg::nix_parcel_t f_out_data;
    logic f_flush;
    logic sin_rise;
    logic cap_push;
    logic pop_tx;

    // Three stages; a level change counts only when stages two and three agree
    assign sin_rise = (r.sin_p[1] == r.sin_p[2]) && r.sin_p[2] && !r.sin_f;
    assign cap_push = (r.state == nix_pkg::NIX_ST_XFER) && r.from_disk && sin_rise
        && !r.term;
    assign pop_tx = (r.state == nix_pkg::NIX_ST_XFER) && !r.from_disk && !r.term
        && (r.phase == nix_pkg::NIX_PH_IDLE) && (r.pending != '0) && !r.abort_req
        && f_out_valid;

    // One buffer serves whichever direction is active
    assign f_in_valid = r.from_disk ? cap_push : host_tx_valid;
    assign f_in_data = r.from_disk ? r.bus_p[2] : host_tx_data;
    assign f_out_ready = r.from_disk ? host_rx_ready : pop_tx;
    assign host_tx_ready = !r.from_disk && f_in_ready;
    assign host_rx_valid = r.from_disk && f_out_valid;
    assign host_rx_data = f_out_data;
    assign f_flush = (r.state == nix_pkg::NIX_ST_STATUS) && status_done && r.term;

    nix_fifo #(
        .W($bits(nix_pkg::nix_parcel_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .flush(f_flush),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    assign drv_out = r.out;
    assign busy = (r.state != nix_pkg::NIX_ST_IDLE);
    assign status_req = (r.state == nix_pkg::NIX_ST_STATUS);
    assign xfer_good = r.good;
    assign overrun = r.overrun;

    always_comb
    begin
        logic inc;
        logic dec;
        inc = 1'b0;
        dec = 1'b0;
        next_r = r;
        next_r.sin_p = {r.sin_p[1:0], drv_in.sync_in};
        next_r.slv_p = {r.slv_p[1:0], drv_in.slave_in};
        next_r.bus_p = {r.bus_p[1:0], drv_in.bus};
        if (r.sin_p[1] == r.sin_p[2])
        begin
            next_r.sin_f = r.sin_p[2];
        end
        if (r.slv_p[1] == r.slv_p[2])
        begin
            next_r.slv_f = r.slv_p[2];
        end
        case (r.state)
            nix_pkg::NIX_ST_IDLE:
            begin
                // Slave acknowledge: Slave In high, Sync In back low
                if (start && bus_ctl_done && r.slv_f && !r.sin_f)
                begin
                    next_r.state = nix_pkg::NIX_ST_XFER;
                    next_r.out.master_out = 1'b1;
                    next_r.from_disk = dir_from_disk;
                    next_r.pending = '0;
                    next_r.post = '0;
                    next_r.term = 1'b0;
                    next_r.abort_req = 1'b0;
                    next_r.overrun = 1'b0;
                end
            end
            nix_pkg::NIX_ST_XFER:
            begin
                // Pulses are counted, not tied to a fixed walk of bus states
                if (abort && !r.term)
                begin
                    next_r.abort_req = 1'b1;
                end
                if (sin_rise)
                begin
                    if (!r.term)
                    begin
                        inc = 1'b1;
                    end
                    else if (!r.from_disk || (r.post != `NIX_POST_TERM_MAX))
                    begin
                        inc = 1'b1;
                        next_r.post = r.post + `NIX_POST_W'(1);
                    end
                end
                // A full buffer cannot refuse the drive, so the parcel is lost
                if (cap_push && !f_in_ready)
                begin
                    next_r.overrun = 1'b1;
                    next_r.abort_req = 1'b1;
                end
                case (r.phase)
                    nix_pkg::NIX_PH_IDLE:
                    begin
                        if (r.pending != '0)
                        begin
                            if (r.abort_req && !r.term)
                            begin
                                next_r.out.master_out = 1'b0;
                                next_r.term = 1'b1;
                                next_r.abort_req = 1'b0;
                                next_r.out.bus_oe_n = 1'b1;
                                next_r.phase = nix_pkg::NIX_PH_HIGH;
                                dec = 1'b1;
                            end
                            else if (r.from_disk || r.term)
                            begin
                                next_r.out.sync_out = 1'b1;
                                next_r.phase = nix_pkg::NIX_PH_HIGH;
                                dec = 1'b1;
                            end
                            else if (pop_tx)
                            begin
                                next_r.out.bus = f_out_data;
                                next_r.out.bus_oe_n = 1'b0;
                                next_r.phase = nix_pkg::NIX_PH_SETUP;
                                dec = 1'b1;
                            end
                        end
                        else if (!r.slv_f)
                        begin
                            next_r.state = nix_pkg::NIX_ST_STATUS;
                            next_r.good = !r.term && !r.abort_req;
                            next_r.out.bus_oe_n = 1'b1;
                        end
                    end
                    nix_pkg::NIX_PH_SETUP:
                    begin
                        // Parcel settles on the buses a cycle before the strobe
                        next_r.out.sync_out = 1'b1;
                        next_r.phase = nix_pkg::NIX_PH_HIGH;
                    end
                    nix_pkg::NIX_PH_HIGH:
                    begin
                        next_r.out.sync_out = 1'b0;
                        next_r.out.master_out = 1'b1;
                        next_r.phase = nix_pkg::NIX_PH_GAP;
                    end
                    default:
                    begin
                        next_r.phase = nix_pkg::NIX_PH_IDLE;
                    end
                endcase
                if (inc && !dec)
                begin
                    next_r.pending = r.pending + PEND_W'(1);
                end
                else if (dec && !inc)
                begin
                    next_r.pending = r.pending - PEND_W'(1);
                end
            end
            nix_pkg::NIX_ST_STATUS:
            begin
                // Master Out is released once the ending status has run
                if (status_done)
                begin
                    next_r.state = nix_pkg::NIX_ST_IDLE;
                    next_r.out.master_out = 1'b0;
                    next_r.phase = nix_pkg::NIX_PH_IDLE;
                end
            end
            default:
            begin
                next_r.state = nix_pkg::NIX_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r <= '0;
            r.out.bus_oe_n <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end
endmodule : nix_seq

// ### inc/nix_defs.svh
// Constants for the noninterlocked disk transfer sequencer
`ifndef NIX_DEFS_SVH
`define NIX_DEFS_SVH
`define NIX_BUS_W 8
`define NIX_FIFO_DEPTH 8
`define NIX_POST_TERM_MAX 4'h8
`define NIX_PEND_W 8
`define NIX_POST_W 4
`endif

// ### inc/nix_pkg.sv
// Types shared by the noninterlocked disk transfer sequencer
`include "nix_defs.svh"
package nix_pkg;
    typedef struct packed
    {
        logic [`NIX_BUS_W-1:0] a;
        logic [`NIX_BUS_W-1:0] b;
    } nix_parcel_t;

    typedef struct packed
    {
        logic slave_in;
        logic sync_in;
        nix_parcel_t bus;
    } nix_drv_in_t;

    typedef struct packed
    {
        logic master_out;
        logic sync_out;
        nix_parcel_t bus;
        logic bus_oe_n;
    } nix_drv_out_t;

    typedef enum logic [1:0]
    {
        NIX_ST_IDLE = 2'b00,
        NIX_ST_XFER = 2'b01,
        NIX_ST_STATUS = 2'b10
    } nix_state_t;

    typedef enum logic [1:0]
    {
        NIX_PH_IDLE = 2'b00,
        NIX_PH_SETUP = 2'b01,
        NIX_PH_HIGH = 2'b10,
        NIX_PH_GAP = 2'b11
    } nix_phase_t;
endpackage : nix_pkg

// ### design/nix_fifo.sv
// Parcel FIFO with valid/ready on both sides
`timescale 1ns/1ps
module nix_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,              // System clock
    input wire logic rst,              // Synchronous reset, active high
    input wire logic flush,            // Drop all stored words
    input wire logic in_valid,         // Write side offers a word
    output logic in_ready,             // Room for a word
    input wire logic [W-1:0] in_data,  // Word written
    output logic out_valid,            // A word is stored
    input wire logic out_ready,        // Read side takes the word
    output logic [W-1:0] out_data      // Oldest word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed
    {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } nix_fifo_st_t;

    nix_fifo_st_t r;
    nix_fifo_st_t next_r;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] idx);
        if (idx == AW'(DEPTH - 1))
        begin
            return '0;
        end
        return idx + AW'(1);
    endfunction : bump

    assign in_ready = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_data = r.mem[r.rd];

    always_comb
    begin
        logic push;
        logic pop;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_r = r;
        if (push)
        begin
            next_r.mem[r.wr] = in_data;
            next_r.wr = bump(r.wr);
        end
        if (pop)
        begin
            next_r.rd = bump(r.rd);
        end
        case ({push, pop})
            2'b10: next_r.cnt = r.cnt + (AW+1)'(1);
            2'b01: next_r.cnt = r.cnt - (AW+1)'(1);
            default: next_r.cnt = r.cnt;
        endcase
        if (flush)
        begin
            next_r.wr = '0;
            next_r.rd = '0;
            next_r.cnt = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end
endmodule : nix_fifo

// ### testbench/nix_seq_chk.sv
// Pin-level assertions for the noninterlocked sequencer
`timescale 1ns/1ps
module nix_seq_chk (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic start, // Start request
    input wire logic bus_ctl_done, // Bus control done
    input wire logic status_done, // Status finished
    input wire logic busy, // Busy
    input wire logic status_req, // Status request
    input wire nix_pkg::nix_drv_in_t drv_in, // Drive pins in
    input wire nix_pkg::nix_drv_out_t drv_out // Drive pins out
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    logic [8:0] owe;
    // Raw pin edges lead the answers, so a negative balance means an extra answer
    always_ff @(posedge clk)
        if (rst || !busy)
            owe <= 9'h0;
        else
            owe <= owe + {8'h0, $rose(drv_in.sync_in)} - {8'h0, $rose(drv_out.sync_out)}
                - {8'h0, $fell(drv_out.master_out)};
    a_start_needs_ctl: assert property ($rose(busy) |->
        $past(start) && $past(bus_ctl_done) && drv_out.master_out)
        else $error("transfer began without bus control");
    a_sync_one_cycle: assert property ($rose(drv_out.sync_out) |=> !drv_out.sync_out [*2])
        else $error("sync out pulse width or gap wrong");
    a_parcel_first: assert property ($rose(drv_out.sync_out) && !drv_out.bus_oe_n |->
        $past(!drv_out.bus_oe_n) && $stable(drv_out.bus))
        else $error("parcel not on bus before sync out");
    a_dip_one_cycle: assert property ($fell(drv_out.master_out) && busy |=> drv_out.master_out)
        else $error("terminating pulse not one cycle");
    a_dip_drops_bus: assert property ($fell(drv_out.master_out) && busy |-> drv_out.bus_oe_n)
        else $error("bus still driven at termination");
    a_dip_no_sync: assert property (!drv_out.master_out && busy |-> !drv_out.sync_out)
        else $error("sync out beside terminating pulse");
    a_status_holds: assert property (status_req && !status_done |=> status_req)
        else $error("ending status dropped early");
    a_idle_quiet: assert property (!busy [*2] |-> !drv_out.sync_out && drv_out.bus_oe_n)
        else $error("link active while idle");
    a_resp_match: assert property (!owe[8])
        else $error("more answers than sync in pulses");
endmodule : nix_seq_chk

// ### testbench/nix_drive_model.sv
// Behavioural disk drive on the far side of the link
`timescale 1ns/1ps
module nix_drive_model (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic go, // Arm a new transfer
    input wire logic from_disk, // Drive sends parcels
    input wire logic [7:0] n, // Pulses to issue
    input wire nix_pkg::nix_drv_out_t drv_out, // Sequencer pins
    output nix_pkg::nix_drv_in_t drv_in, // Drive pins
    output logic [7:0] rsp // Answers seen
);
    nix_pkg::nix_parcel_t got[$];
    logic [7:0] sent;
    logic [2:0] tmr;
    logic so_q, mo_q, adv;
    // Pulses only once transfer ready is shown, and never wait for earlier answers
    assign adv = drv_out.master_out && drv_in.slave_in && (sent != n || tmr != 3'h0);
    always @(posedge clk)
    begin
        so_q <= drv_out.sync_out;
        mo_q <= drv_out.master_out;
        if (rst || go)
        begin
            drv_in <= '0;
            drv_in.slave_in <= 1'b1;
            sent <= 8'h0;
            rsp <= 8'h0;
            tmr <= 3'h0;
            got.delete();
        end
        else
        begin
            rsp <= rsp + {7'h0, drv_out.sync_out && !so_q}
                + {7'h0, !drv_out.master_out && mo_q && drv_in.slave_in};
            if (drv_out.sync_out && !so_q && !drv_out.bus_oe_n)
                got.push_back(drv_out.bus);
            if (adv)
                tmr <= tmr + 3'h1;
            if (adv && tmr == 3'h1)
                drv_in.sync_in <= 1'b1;
            if (adv && tmr == 3'h5)
            begin
                drv_in.sync_in <= 1'b0;
                sent <= sent + 8'h1;
            end
            // Bus released toward the disk, so it toggles rather than holding
            if (!from_disk)
                drv_in.bus <= ~drv_in.bus;
            else if (adv && tmr == 3'h0)
                drv_in.bus <= {8'ha0 + sent, 8'h50 + sent};
            if (drv_out.master_out && sent == n && rsp == n && tmr == 3'h0)
                drv_in.slave_in <= 1'b0;
        end
    end
endmodule : nix_drive_model

// ### testbench/nix_seq_tb.sv
// Self-checking bench for the noninterlocked sequencer
`timescale 1ns/1ps
module nix_seq_tb;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, dir_from_disk = 1'b0, bus_ctl_done = 1'b0;
    logic abort = 1'b0, status_done = 1'b0, host_tx_valid = 1'b0, host_rx_ready = 1'b0;
    logic go = 1'b0, from_disk = 1'b0, host_tx_ready, host_rx_valid, busy, status_req;
    logic xfer_good, overrun;
    logic [7:0] n = 8'h0, rsp;
    nix_pkg::nix_parcel_t host_tx_data = '0, host_rx_data;
    nix_pkg::nix_drv_in_t drv_in;
    nix_pkg::nix_drv_out_t drv_out;
    int compares = 0, miscompares = 0, cycles = 0;
    always #50 clk = ~clk;
    nix_seq DUT (.clk(clk), .rst(rst), .start(start), .dir_from_disk(dir_from_disk),
        .bus_ctl_done(bus_ctl_done), .abort(abort), .status_done(status_done),
        .host_tx_valid(host_tx_valid), .host_tx_ready(host_tx_ready),
        .host_tx_data(host_tx_data), .host_rx_valid(host_rx_valid),
        .host_rx_ready(host_rx_ready), .host_rx_data(host_rx_data), .busy(busy),
        .status_req(status_req), .xfer_good(xfer_good), .overrun(overrun),
        .drv_in(drv_in), .drv_out(drv_out));
    nix_drive_model drv (.clk(clk), .rst(rst), .go(go), .from_disk(from_disk), .n(n),
        .drv_out(drv_out), .drv_in(drv_in), .rsp(rsp));
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic push(input int cnt);
        for (int i = 0; i < cnt; i++)
        begin
            @(negedge clk);
            host_tx_valid = 1'b1;
            host_tx_data = {8'h10 + i[7:0], 8'h80 + i[7:0]};
            while (host_tx_ready !== 1'b1)
                @(negedge clk);
        end
        @(negedge clk);
        host_tx_valid = 1'b0;
    endtask : push
    task automatic xfer(input logic dir, input logic [7:0] cnt, input logic [7:0] cut,
        input logic good);
        @(negedge clk);
        go = 1'b1;
        n = cnt;
        from_disk = dir;
        @(negedge clk);
        go = 1'b0;
        repeat (4) @(negedge clk);
        start = 1'b1;
        dir_from_disk = dir;
        bus_ctl_done = 1'b1;
        @(negedge clk);
        start = 1'b0;
        @(negedge clk);
        chk("master_out", 16'h1, {15'h0, drv_out.master_out});
        if (cut != 8'h0)
        begin
            while (rsp < cut)
                @(negedge clk);
            abort = 1'b1;
            @(negedge clk);
            abort = 1'b0;
        end
        while (status_req !== 1'b1)
            @(negedge clk);
        chk("answers", {8'h0, cnt}, {8'h0, rsp});
        chk("xfer_good", {15'h0, good}, {15'h0, xfer_good});
        status_done = 1'b1;
        bus_ctl_done = 1'b0;
        @(negedge clk);
        status_done = 1'b0;
        @(negedge clk);
        chk("busy", 16'h0, {15'h0, busy});
    endtask : xfer
    task automatic t_refuse();
        start = 1'b1;
        repeat (6) @(negedge clk);
        start = 1'b0;
        chk("busy", 16'h0, {15'h0, busy});
        chk("master_out", 16'h0, {15'h0, drv_out.master_out});
        chk("bus_oe_n", 16'h1, {15'h0, drv_out.bus_oe_n});
        chk("status_req", 16'h0, {15'h0, status_req});
    endtask : t_refuse
    task automatic t_to_disk();
        push(8);
        chk("tx_ready", 16'h0, {15'h0, host_tx_ready});
        xfer(1'b0, 8'h8, 8'h0, 1'b1);
        for (int i = 0; i < 8; i++)
            chk("parcel", {8'h10 + i[7:0], 8'h80 + i[7:0]}, drv.got[i]);
        chk("tx_ready", 16'h1, {15'h0, host_tx_ready});
    endtask : t_to_disk
    task automatic t_abort_to();
        push(6);
        xfer(1'b0, 8'h6, 8'h2, 1'b0);
        chk("parcels", 16'h2, 16'(drv.got.size()));
    endtask : t_abort_to
    task automatic t_from_disk();
        xfer(1'b1, 8'h5, 8'h0, 1'b1);
        chk("overrun", 16'h0, {15'h0, overrun});
        for (int i = 0; i < 5; i++)
        begin
            @(negedge clk);
            chk("rx_valid", 16'h1, {15'h0, host_rx_valid});
            chk("rx_data", {8'ha0 + i[7:0], 8'h50 + i[7:0]}, host_rx_data);
            host_rx_ready = 1'b1;
        end
        @(negedge clk);
        host_rx_ready = 1'b0;
        chk("rx_valid", 16'h0, {15'h0, host_rx_valid});
    endtask : t_from_disk
    task automatic t_abort_from();
        // Third pulse gets the terminating dip, the last eight reach the post limit
        xfer(1'b1, 8'hb, 8'h2, 1'b0);
        chk("rx_valid", 16'h0, {15'h0, host_rx_valid});
        chk("overrun", 16'h0, {15'h0, overrun});
    endtask : t_abort_from
    task automatic t_overrun();
        // Host never reads, so the ninth parcel finds the buffer full
        xfer(1'b1, 8'h9, 8'h0, 1'b0);
        chk("overrun", 16'h1, {15'h0, overrun});
        chk("rx_valid", 16'h0, {15'h0, host_rx_valid});
    endtask : t_overrun
    initial
    begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_refuse();
        t_to_disk();
        t_abort_to();
        t_from_disk();
        t_abort_from();
        t_overrun();
        wrap_up();
    end
endmodule : nix_seq_tb
bind nix_seq nix_seq_chk u_chk (.clk(clk), .rst(rst), .start(start),
    .bus_ctl_done(bus_ctl_done), .status_done(status_done), .busy(busy),
    .status_req(status_req), .drv_in(drv_in), .drv_out(drv_out));
